// [common/dprc_pkg.sv]
// Shared constants and types for the debug probe reset and link control.
package dprc_pkg;
   // Core clock and millisecond time base.
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
   // Test clock half period, rounded up to whole core cycles.
   localparam int TCK_HALF_NS = 500;
   localparam int TCK_HALF_CYCLES =
      (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Test mode select high edges that force the TAP into reset.
   localparam int TMS_RESET_EDGES = 5;
   // Protocol switching sequence: ones, a 16-bit pattern, ones again.
   localparam int SWITCH_ONES = 56;
   localparam int SWITCH_PAT_BITS = 16;
   localparam int SWITCH_TOTAL = 2 * SWITCH_ONES + SWITCH_PAT_BITS;
   localparam logic [15:0] SWITCH_SEQ_STD = 16'he79e;
   localparam logic [15:0] SWITCH_SEQ_LEGACY = 16'hb76d;
   // Width of the millisecond settings and of the trace bit timer.
   localparam int MS_W = 16;
   localparam int BAUD_W = 16;
   localparam int TRACE_BITS = 8;

   typedef enum logic [2:0] {
      RST_SYS = 3'h0,
      RST_TAP = 3'h1,
      RST_BOTH = 3'h2,
      RST_SOFT = 3'h3,
      RST_CORE_REG = 3'h4
   } dprc_rst_type_t;

   typedef enum logic [1:0] {
      DRV_STRONG = 2'h0,
      DRV_WEAK = 2'h1,
      DRV_OFF = 2'h2
   } dprc_drive_t;
endpackage : dprc_pkg

// [common/dprc_trace_if.sv]
// Link between the reset controller and the single-wire trace receiver.
`timescale 1ns/100ps
`default_nettype none
interface dprc_trace_if;
   import dprc_pkg::*;
   logic nrz_mode;
   logic [BAUD_W-1:0] baud_div;
   logic [TRACE_BITS-1:0] data;
   logic valid;
   logic frame_err;
   logic [BAUD_W-1:0] bit_period;
   modport rx (input nrz_mode, baud_div,
      output data, valid, frame_err, bit_period);
   modport ctl (output nrz_mode, baud_div,
      input data, valid, frame_err, bit_period);
endinterface : dprc_trace_if
`default_nettype wire

// [hdl/dprc_trace_rx.sv]
// Single-wire trace receiver for Manchester and NRZ streams.
`timescale 1ns/100ps
`default_nettype none
module dprc_trace_rx
   import dprc_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Trace line from the target.
   input wire logic single_wire_trace_out_i,
   // Configuration and decoded data.
   dprc_trace_if.rx tr
);
   typedef enum logic [3:0] {
      T_IDLE = 4'b0001,
      T_MEAS = 4'b0010,
      T_BITS = 4'b0100,
      T_STOP = 4'b1000
   } dprc_trx_state_t;

   dprc_trx_state_t state_reg;
   logic sync1_reg, sync2_reg, prev_reg;
   logic [BAUD_W-1:0] timer_reg, width_reg, period_reg, auto_reg;
   logic [3:0] bit_cnt_reg;
   logic [TRACE_BITS-1:0] shift_reg;
   logic [BAUD_W-1:0] period_now;

   // Two flip-flops before the line is looked at.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= single_wire_trace_out_i;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // A zero baud setting falls back to the learned bit time.
   always_comb
   begin
      if (!tr.nrz_mode)
         period_now = {width_reg[BAUD_W-2:0], 1'b0};
      else if (tr.baud_div != '0)
         period_now = tr.baud_div;
      else
         period_now = (auto_reg != '0) ? auto_reg : width_reg;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_reg <= T_IDLE;
         timer_reg <= '0;
         width_reg <= '0;
         period_reg <= '0;
         auto_reg <= '0;
         bit_cnt_reg <= 4'h0;
         shift_reg <= '0;
         tr.data <= '0;
         tr.valid <= 1'b0;
         tr.frame_err <= 1'b0;
      end
      else
      begin
         tr.valid <= 1'b0;
         tr.frame_err <= 1'b0;
         case (state_reg)
            T_IDLE:
            begin
               // NRZ start is a falling edge, Manchester start a rise.
               if (prev_reg != sync2_reg && sync2_reg != tr.nrz_mode)
               begin
                  width_reg <= 16'h0001;
                  state_reg <= T_MEAS;
               end
            end
            T_MEAS:
            begin
               if (sync2_reg == tr.nrz_mode)
               begin
                  period_reg <= period_now;
                  if (tr.nrz_mode && tr.baud_div == '0 && auto_reg == '0)
                     auto_reg <= width_reg;
                  timer_reg <= tr.nrz_mode ? (period_now >> 1) :
                     period_now + (period_now >> 2);
                  bit_cnt_reg <= 4'h0;
                  state_reg <= T_BITS;
               end
               else if (width_reg != '1)
                  width_reg <= width_reg + 16'h0001;
            end
            T_BITS:
            begin
               if (timer_reg == '0)
               begin
                  shift_reg <= {sync2_reg, shift_reg[TRACE_BITS-1:1]};
                  timer_reg <= period_reg - 16'h0001;
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  if (bit_cnt_reg == 4'(TRACE_BITS - 1))
                     state_reg <= T_STOP;
               end
               else
                  timer_reg <= timer_reg - 16'h0001;
            end
            T_STOP:
            begin
               if (timer_reg == '0 || !tr.nrz_mode)
               begin
                  tr.data <= shift_reg;
                  tr.valid <= 1'b1;
                  tr.frame_err <= tr.nrz_mode && !sync2_reg;
                  state_reg <= T_IDLE;
               end
               else
                  timer_reg <= timer_reg - 16'h0001;
            end
            default:
               state_reg <= T_IDLE;
         endcase
      end
   end

   assign tr.bit_period = period_reg;
endmodule : dprc_trace_rx
`default_nettype wire

// [hdl/dprc_reset_ctrl.sv]
// Probe-side target reset, protocol selection and trace receive control.
//
// Functional notes
// - System type pulls the target system reset low; encoding zero is default.
// - TAP type pulls only the TAP reset line low.
// - Combined type pulls both reset lines low together.
// - Soft type asserts no line; asks debug engine for supervisor and vector.
// - Core-register type asks debug engine to write the core reset register.
// - TAP reset on connect resets the TAP at every connection.
// - System reset on connect asserts system reset for first device only.
// - Lines are held low together for the longer of their enabled millisecond hold times.
// - After release, wait the longer of the enabled system and TAP millisecond delays.
// - TAP reset delay is its own millisecond setting, used alone when only TAP is reset.
// - Optional TMS stepping resets the TAP besides the TAP reset line.
// - If allowed, extend target-initiated reset until setup ends; else never.
// - Latching allowed means TAP reset is done while system reset held.
// - Inactive level is driven strong, weak or not at all.
// - Active level is driven strong, weak or not at all.
// - Interface mode picks JTAG or serial wire debug.
// - Switching sequence is sent before connecting when enabled.
// - Legacy option sends the older switching pattern instead.
// - Trace receiver decodes Manchester or NRZ data.
// - NRZ uses programmed baud; zero means detect the rate automatically.
`timescale 1ns/100ps
`default_nettype none
module dprc_reset_ctrl
   import dprc_pkg::*;
#(
   parameter int MS_CYCLES = CYCLES_PER_MS
)
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Requests and handshake with the debug engine.
   input wire logic connect_req,
   input wire logic first_connect,
   input wire logic reset_req,
   input wire logic debug_op_done,
   output logic soft_reset_req,
   output logic core_reg_reset_req,
   output logic busy,
   output logic post_reset_done,
   // Reset configuration.
   input wire logic [2:0] reset_type,
   input wire logic tap_reset_on_connect,
   input wire logic sys_reset_on_connect,
   input wire logic [MS_W-1:0] sys_hold_ms,
   input wire logic [MS_W-1:0] sys_delay_ms,
   input wire logic [MS_W-1:0] tap_hold_ms,
   input wire logic [MS_W-1:0] tap_delay_ms,
   input wire logic tap_reset_by_tms,
   input wire logic allow_reset_extend,
   input wire logic allow_reset_latch,
   input wire logic [1:0] sys_high_mode,
   input wire logic [1:0] sys_low_mode,
   input wire logic [1:0] tap_high_mode,
   input wire logic [1:0] tap_low_mode,
   // Protocol configuration.
   input wire logic iface_swd,
   input wire logic protocol_switch_en,
   input wire logic protocol_switch_legacy,
   output logic protocol_is_swd,
   // Trace configuration and data.
   input wire logic trace_nrz_mode,
   input wire logic [BAUD_W-1:0] trace_baud_div,
   output logic [TRACE_BITS-1:0] trace_data,
   output logic trace_valid,
   output logic trace_frame_err,
   output logic [BAUD_W-1:0] trace_bit_period,
   // Target reset pins.
   input wire logic target_system_reset_n_i,
   output logic target_system_reset_n_o,
   output logic target_system_reset_n_oe,
   output logic target_system_reset_weak,
   output logic tap_reset_n_o,
   output logic tap_reset_n_oe,
   output logic tap_reset_weak,
   // Debug link pins.
   output logic link_clk_o,
   output logic link_tms_o,
   output logic link_tms_oe,
   input wire logic single_wire_trace_out_i
);
   typedef enum logic [6:0] {
      S_IDLE = 7'b000_0001,
      S_SWITCH = 7'b000_0010,
      S_HOLD = 7'b000_0100,
      S_TMS = 7'b000_1000,
      S_DELAY = 7'b001_0000,
      S_CORE = 7'b010_0000,
      S_DONE = 7'b100_0000
   } dprc_state_t;

   dprc_state_t state_reg, state_next;
   logic want_sys_reg, want_sys_next;
   logic want_tap_reg, want_tap_next;
   logic want_tms_reg, want_tms_next;
   logic ext_reg, ext_next;
   logic soft_reg, soft_next;
   logic srst_sync1_reg, srst_sync2_reg;
   logic [1:0] echo_reg;
   logic [31:0] ms_pre_reg;
   logic [MS_W-1:0] ms_cnt_reg;
   logic [7:0] tck_div_reg;
   logic tck_reg, tms_reg;
   logic [7:0] bit_cnt_reg;
   logic tck_run, tck_toggle, tck_rise, tck_fall;
   logic ms_tick, load_hold, load_delay;
   logic drive_sys, drive_tap;
   logic [1:0] sys_pin, tap_pin;
   logic ext_go;

   dprc_trace_if trace_link ();

   // Pick the longer of two enabled millisecond settings.
   function automatic logic [MS_W-1:0] longer_ms(
      input logic a_en,
      input logic [MS_W-1:0] a,
      input logic b_en,
      input logic [MS_W-1:0] b);
      logic [MS_W-1:0] av, bv;
      av = a_en ? a : '0;
      bv = b_en ? b : '0;
      return (av > bv) ? av : bv;
   endfunction : longer_ms

   // Map a drive mode to {enable, weak}.
   function automatic logic [1:0] pin_drive(input logic [1:0] mode);
      return {mode != DRV_OFF, mode == DRV_WEAK};
   endfunction : pin_drive

   // Switching sequence bit for a given position.
   function automatic logic switch_bit(
      input logic [7:0] idx,
      input logic legacy);
      logic [15:0] pat;
      pat = legacy ? SWITCH_SEQ_LEGACY : SWITCH_SEQ_STD;
      if (idx < 8'(SWITCH_ONES) ||
         idx >= 8'(SWITCH_ONES + SWITCH_PAT_BITS))
         return 1'b1;
      return pat[4'(idx - 8'(SWITCH_ONES))];
   endfunction : switch_bit

   // Target system reset level passes two flip-flops.
   always_ff @(posedge sys_clk)
   begin
      echo_reg <= {echo_reg[0], !target_system_reset_n_o};
      if (reset)
      begin
         srst_sync1_reg <= 1'b1;
         srst_sync2_reg <= 1'b1;
      end
      else
      begin
         srst_sync1_reg <= target_system_reset_n_i;
         srst_sync2_reg <= srst_sync1_reg;
      end
   end

   assign ext_go = !srst_sync2_reg && echo_reg == '0 &&
      allow_reset_extend;

   // Sequencing of connect, reset and post-reset setup.
   always_comb
   begin
      state_next = state_reg;
      want_sys_next = want_sys_reg;
      want_tap_next = want_tap_reg;
      want_tms_next = want_tms_reg;
      ext_next = ext_reg;
      soft_next = soft_reg;
      load_hold = 1'b0;
      load_delay = 1'b0;
      case (state_reg)
         S_IDLE:
         begin
            if (connect_req)
            begin
               want_sys_next = sys_reset_on_connect && first_connect;
               want_tap_next = tap_reset_on_connect ||
                  (allow_reset_latch && sys_reset_on_connect &&
                  first_connect);
               want_tms_next = tap_reset_by_tms && want_tap_next;
               ext_next = 1'b0;
               if (protocol_switch_en)
                  state_next = S_SWITCH;
               else if (want_sys_next || want_tap_next)
               begin
                  state_next = S_HOLD;
                  load_hold = 1'b1;
               end
               else
                  state_next = S_DONE;
            end
            else if (reset_req)
            begin
               ext_next = 1'b0;
               want_sys_next = reset_type == RST_SYS ||
                  reset_type == RST_BOTH;
               want_tap_next = reset_type == RST_TAP ||
                  reset_type == RST_BOTH ||
                  (allow_reset_latch && want_sys_next);
               want_tms_next = tap_reset_by_tms && want_tap_next;
               soft_next = reset_type == RST_SOFT;
               if (reset_type == RST_SOFT || reset_type == RST_CORE_REG)
               begin
                  want_sys_next = 1'b0;
                  want_tap_next = 1'b0;
                  want_tms_next = 1'b0;
                  state_next = S_CORE;
               end
               else
               begin
                  state_next = S_HOLD;
                  load_hold = 1'b1;
               end
            end
            else if (ext_go)
            begin
               ext_next = 1'b1;
               want_sys_next = 1'b1;
               want_tap_next = allow_reset_latch;
               want_tms_next = allow_reset_latch && tap_reset_by_tms;
               state_next = S_HOLD;
               load_hold = 1'b1;
            end
         end
         S_SWITCH:
         begin
            if (tck_rise && bit_cnt_reg == 8'(SWITCH_TOTAL - 1))
            begin
               if (want_sys_reg || want_tap_reg)
               begin
                  state_next = S_HOLD;
                  load_hold = 1'b1;
               end
               else
                  state_next = S_DONE;
            end
         end
         S_HOLD:
         begin
            if (ms_cnt_reg == '0)
            begin
               if (want_tms_reg)
                  state_next = S_TMS;
               else
               begin
                  state_next = S_DELAY;
                  load_delay = 1'b1;
               end
            end
         end
         S_TMS:
         begin
            if (tck_rise && bit_cnt_reg == 8'(TMS_RESET_EDGES - 1))
            begin
               state_next = S_DELAY;
               load_delay = 1'b1;
            end
         end
         S_DELAY:
         begin
            if (ms_cnt_reg == '0)
               state_next = S_DONE;
         end
         S_CORE:
         begin
            if (debug_op_done)
               state_next = S_DONE;
         end
         S_DONE:
            state_next = S_IDLE;
         default:
            state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_reg <= S_IDLE;
         want_sys_reg <= 1'b0;
         want_tap_reg <= 1'b0;
         want_tms_reg <= 1'b0;
         ext_reg <= 1'b0;
         soft_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         want_sys_reg <= want_sys_next;
         want_tap_reg <= want_tap_next;
         want_tms_reg <= want_tms_next;
         ext_reg <= ext_next;
         soft_reg <= soft_next;
      end
   end

   // Millisecond timer for hold times and post-reset delays.
   assign ms_tick = ms_pre_reg == 32'(MS_CYCLES - 1);

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ms_pre_reg <= '0;
         ms_cnt_reg <= '0;
      end
      else if (load_hold)
      begin
         ms_pre_reg <= '0;
         ms_cnt_reg <= longer_ms(want_sys_next, sys_hold_ms,
            want_tap_next, tap_hold_ms);
      end
      else if (load_delay)
      begin
         ms_pre_reg <= '0;
         ms_cnt_reg <= longer_ms(want_sys_reg, sys_delay_ms,
            want_tap_reg, tap_delay_ms);
      end
      else if (ms_cnt_reg != '0)
      begin
         ms_pre_reg <= ms_tick ? '0 : ms_pre_reg + 32'd1;
         if (ms_tick)
            ms_cnt_reg <= ms_cnt_reg - 16'h0001;
      end
   end

   // Test clock generation and TMS shifting.
   assign tck_run = state_reg == S_SWITCH || state_reg == S_TMS;
   assign tck_toggle = tck_run && tck_div_reg == 8'(TCK_HALF_CYCLES - 1);
   assign tck_rise = tck_toggle && !tck_reg;
   assign tck_fall = tck_toggle && tck_reg;

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         tck_div_reg <= '0;
         tck_reg <= 1'b0;
      end
      else if (!tck_run)
      begin
         tck_div_reg <= '0;
         tck_reg <= 1'b0;
      end
      else
      begin
         tck_div_reg <= tck_toggle ? '0 : tck_div_reg + 8'd1;
         if (tck_toggle)
            tck_reg <= !tck_reg;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         bit_cnt_reg <= '0;
         tms_reg <= 1'b1;
      end
      else if (!tck_run)
      begin
         bit_cnt_reg <= '0;
         tms_reg <= 1'b1;
      end
      else
      begin
         if (tck_rise)
            bit_cnt_reg <= bit_cnt_reg + 8'd1;
         if (tck_fall && state_reg == S_SWITCH)
            tms_reg <= switch_bit(bit_cnt_reg, protocol_switch_legacy);
      end
   end

   // Reset line levels and drive modes.
   assign drive_sys = want_sys_reg && (state_reg == S_HOLD ||
      (ext_reg && (state_reg == S_TMS || state_reg == S_DELAY)));
   assign drive_tap = want_tap_reg && state_reg == S_HOLD;
   assign sys_pin = pin_drive(drive_sys ? sys_low_mode : sys_high_mode);
   assign tap_pin = pin_drive(drive_tap ? tap_low_mode : tap_high_mode);

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         target_system_reset_n_o <= 1'b1;
         target_system_reset_n_oe <= 1'b0;
         target_system_reset_weak <= 1'b0;
         tap_reset_n_o <= 1'b1;
         tap_reset_n_oe <= 1'b0;
         tap_reset_weak <= 1'b0;
      end
      else
      begin
         target_system_reset_n_o <= !drive_sys;
         target_system_reset_n_oe <= sys_pin[1];
         target_system_reset_weak <= sys_pin[0];
         tap_reset_n_o <= !drive_tap;
         tap_reset_n_oe <= tap_pin[1];
         tap_reset_weak <= tap_pin[0];
      end
   end

   // Protocol selection and status.
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         protocol_is_swd <= 1'b0;
      else if (state_reg == S_IDLE)
         protocol_is_swd <= iface_swd;
   end

   assign link_clk_o = tck_reg;
   assign link_tms_o = tms_reg;
   assign link_tms_oe = 1'b1;
   assign soft_reset_req = state_reg == S_CORE && soft_reg;
   assign core_reg_reset_req = state_reg == S_CORE && !soft_reg;
   assign busy = state_reg != S_IDLE;
   assign post_reset_done = state_reg == S_DONE;

   // Trace receiver.
   assign trace_link.nrz_mode = trace_nrz_mode;
   assign trace_link.baud_div = trace_baud_div;
   assign trace_data = trace_link.data;
   assign trace_valid = trace_link.valid;
   assign trace_frame_err = trace_link.frame_err;
   assign trace_bit_period = trace_link.bit_period;

   dprc_trace_rx u_trace_rx (
      .sys_clk(sys_clk),
      .reset(reset),
      .single_wire_trace_out_i(single_wire_trace_out_i),
      .tr(trace_link.rx)
   );
endmodule : dprc_reset_ctrl
`default_nettype wire

// [bench/dprc_checker.sv]
// Port assertions for the probe reset controller.
`timescale 1ns/100ps
`default_nettype none
module dprc_checker
   import dprc_pkg::*;
(
   // Clock, requests and settings.
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic reset_req,
   input wire logic connect_req,
   input wire logic [2:0] reset_type,
   input wire logic allow_reset_extend,
   input wire logic [1:0] sys_high_mode,
   input wire logic [1:0] sys_low_mode,
   input wire logic [MS_W-1:0] sys_delay_ms,
   input wire logic iface_swd,
   // Watched outputs and line readback.
   input wire logic busy,
   input wire logic post_reset_done,
   input wire logic soft_reset_req,
   input wire logic core_reg_reset_req,
   input wire logic protocol_is_swd,
   input wire logic target_system_reset_n_i,
   input wire logic target_system_reset_n_o,
   input wire logic target_system_reset_n_oe,
   input wire logic target_system_reset_weak,
   input wire logic tap_reset_n_o
);
   default clocking dck @(posedge sys_clk); endclocking
   default disable iff (reset);
   wire logic go = reset_req && !busy && !connect_req;
   sys_type_a: assert property (go && reset_type == RST_SYS |-> ##2
      !target_system_reset_n_o) else $error("sys type");
   tap_type_a: assert property (go && reset_type == RST_TAP |-> ##2
      !tap_reset_n_o && target_system_reset_n_o) else $error("tap type");
   both_type_a: assert property (go && reset_type == RST_BOTH |-> ##2
      !tap_reset_n_o && !target_system_reset_n_o) else $error("both type");
   soft_lines_a: assert property (soft_reset_req |->
      tap_reset_n_o && target_system_reset_n_o) else $error("soft line");
   core_lines_a: assert property (core_reg_reset_req |->
      tap_reset_n_o && target_system_reset_n_o) else $error("core line");
   sys_delay_a: assert property ($rose(target_system_reset_n_o) && busy
      && sys_delay_ms == 1 |-> !post_reset_done [*8]) else $error("delay");
   no_extend_a: assert property (!allow_reset_extend && !busy &&
      !reset_req && !connect_req |=> !busy) else $error("extended");
   ext_start_a: assert property (allow_reset_extend && !busy &&
      $fell(target_system_reset_n_i) |-> ##[1:6] busy) else $error("ext");
   high_mode_a: assert property (target_system_reset_n_o && !busy &&
      sys_high_mode == DRV_WEAK && $stable(sys_high_mode) && !$past(reset)
      |-> target_system_reset_n_oe && target_system_reset_weak)
      else $error("weak high");
   low_mode_a: assert property (!target_system_reset_n_o &&
      sys_low_mode == DRV_OFF |-> !target_system_reset_n_oe)
      else $error("low drive");
   proto_sel_a: assert property (!busy && $stable(iface_swd) &&
      !$past(reset) |=> protocol_is_swd == iface_swd) else $error("proto");
endmodule : dprc_checker
bind dprc_reset_ctrl dprc_checker chk_u (.*);
`default_nettype wire

// [bench/dprc_target_model.sv]
// Target side: pulled-up system reset line and a trace sender.
`timescale 1ns/100ps
`default_nettype none
module dprc_target_model (
   // Probe pins and the target's own reset request.
   input wire logic target_system_reset_n_o,
   input wire logic target_system_reset_n_oe,
   input wire logic target_pull,
   // Lines read by the probe.
   output logic target_system_reset_n_i,
   output var logic single_wire_trace_out_i
);
   // The pull-up wins unless either party pulls the line low.
   assign target_system_reset_n_i = !(target_pull ||
      (target_system_reset_n_oe && !target_system_reset_n_o));
   initial single_wire_trace_out_i = 1'b1;
   // Sends a frame: low start bit, data least bit first, high stop bit.
   task automatic send_nrz(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         single_wire_trace_out_i = f[i];
         #125;
      end
   endtask : send_nrz
endmodule : dprc_target_model
`default_nettype wire

// [bench/dprc_reset_ctrl_bench.sv]
// Self-checking bench for the probe reset controller.
`timescale 1ns/100ps
`default_nettype none
module dprc_reset_ctrl_bench;
   import dprc_pkg::*;
   localparam int MSC = 20;
   logic sys_clk = 0, reset = 1, connect_req = 0, first_connect = 1;
   logic reset_req = 0, debug_op_done = 0, tap_reset_on_connect = 0;
   logic sys_reset_on_connect = 1, tap_reset_by_tms = 1, target_pull = 0;
   logic allow_reset_extend = 0, allow_reset_latch = 0, iface_swd = 1;
   logic protocol_switch_en = 1, protocol_switch_legacy = 0;
   logic trace_nrz_mode = 1;
   logic [2:0] reset_type = 0;
   logic [MS_W-1:0] sys_hold_ms = 1, sys_delay_ms = 1;
   logic [MS_W-1:0] tap_hold_ms = 1, tap_delay_ms = 1;
   logic [1:0] sys_high_mode = DRV_WEAK, sys_low_mode = DRV_STRONG;
   logic [1:0] tap_high_mode = DRV_STRONG, tap_low_mode = DRV_WEAK;
   logic [BAUD_W-1:0] trace_baud_div = 0, trace_bit_period;
   logic soft_reset_req, core_reg_reset_req, busy, post_reset_done;
   logic protocol_is_swd, trace_valid, trace_frame_err;
   logic [TRACE_BITS-1:0] trace_data;
   logic target_system_reset_n_i, target_system_reset_n_o;
   logic target_system_reset_n_oe, target_system_reset_weak;
   logic tap_reset_n_o, tap_reset_n_oe, tap_reset_weak;
   logic link_clk_o, link_tms_o, link_tms_oe, single_wire_trace_out_i;
   logic seen_sys, seen_tap, lclk;
   logic [127:0] sw;
   int errors = 0, n_compared = 0, cyc = 0, n_cyc, low_n, nb;
   dprc_reset_ctrl #(.MS_CYCLES(MSC)) dut_u (.*);
   dprc_target_model far_u (.*);
   initial forever #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000) give_verdict(1);
   end
   task automatic tick;
      @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] seen, exp, input string m);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic give_verdict(input int extra);
      errors += extra;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   // Runs one sequence to its end.
   task automatic run_seq;
      {seen_sys, seen_tap, lclk, low_n, nb} = 0;
      for (n_cyc = 0; n_cyc < 20000 && post_reset_done !== 1; n_cyc++)
      begin
         tick;
         seen_sys |= !target_system_reset_n_o;
         seen_tap |= !tap_reset_n_o;
         low_n += !target_system_reset_n_o;
         debug_op_done = soft_reset_req | core_reg_reset_req;
         if (link_clk_o && !lclk && nb++ < 128) sw = {link_tms_o, sw[127:1]};
         lclk = link_clk_o;
      end
      chk(n_cyc < 20000, 1, "sequence end");
      tick;
   endtask : run_seq
   task automatic t_type(input logic [2:0] ty, input logic es, et);
      reset_type = ty;
      reset_req = 1;
      tick;
      reset_req = 0;
      chk(busy, 1, "busy");
      run_seq;
      chk(seen_sys, es, "system line");
      chk(seen_tap, et, "tap line");
      if (es) chk(low_n >= MSC && low_n <= MSC + 3, 1, "hold");
      if (ty < 3) chk(n_cyc > 2 * MSC, 1, "post delay");
      $display("test type %0d done", ty);
   endtask : t_type
   task automatic t_connect(input logic leg);
      protocol_switch_legacy = leg;
      connect_req = 1;
      tick;
      connect_req = 0;
      run_seq;
      chk(sw[71:56], leg ? SWITCH_SEQ_LEGACY : SWITCH_SEQ_STD, "pat");
      chk(&sw[55:0] && &sw[127:72], 1, "switch ones");
      chk(seen_sys, 1, "reset on connect");
      chk(protocol_is_swd, 1, "swd mode");
      $display("test connect %0d done", leg);
   endtask : t_connect
   task automatic t_extend(input logic al);
      allow_reset_extend = al;
      target_pull = 1;
      repeat (8) tick;
      target_pull = 0;
      chk(busy, al, "extension");
      chk(target_system_reset_n_o, !al, "line held");
      if (al) run_seq;
      $display("test extend %0d done", al);
   endtask : t_extend
   task automatic t_trace;
      fork
         far_u.send_nrz(8'h5b);
      join_none
      for (n_cyc = 0; n_cyc < 300 && trace_valid !== 1; n_cyc++) tick;
      chk(trace_data, 8'h5b, "nrz byte");
      chk(trace_frame_err, 0, "stop bit");
      chk(trace_bit_period, 12, "bit time");
      $display("test trace done");
   endtask : t_trace
   initial
   begin
      repeat (10) tick;
      reset = 0;
      tick;
      chk(target_system_reset_n_oe, 1, "weak high drive");
      chk(target_system_reset_weak, 1, "weak high flag");
      for (int t = 0; t < 5; t++) t_type(t, t == 0 || t == 2, t == 1 || t == 2);
      t_connect(0);
      t_connect(1);
      sys_high_mode = DRV_OFF;
      sys_low_mode = DRV_OFF;
      tick;
      tick;
      chk(target_system_reset_n_oe, 0, "high undriven");
      t_extend(0);
      t_extend(1);
      t_type(0, 1, 0);
      t_trace;
      give_verdict(0);
   end
endmodule : dprc_reset_ctrl_bench
`default_nettype wire
